// *** common/rtwm_pkg.sv ***
// Contract
// - multiply working register by addressed operand, unsigned.
// - 16-bit product, high byte to product_high, low byte to product_low.
// - working register and operand stay unchanged; only product pair written.
// - no status flag changes; no carry, overflow or zero signalled.
// - access bit 0 selects access bank; 1 uses bank select register.
// - extended set, access bit 0, address at most 95: indexed literal offset.
// - one word, one cycle: decode Q1, read Q2, multiply Q3, write Q4.
package rtwm_pkg;
  // ****************************************
  // phases and addressing
  // ****************************************
  typedef enum logic [1:0] {
    RTWM_Q1 = 2'b00,
    RTWM_Q2 = 2'b01,
    RTWM_Q3 = 2'b10,
    RTWM_Q4 = 2'b11
  } rtwm_phase_e;

  localparam logic [7:0]  RTWM_INDEXED_MAX   = 8'h5F;
  localparam logic [7:0]  RTWM_ACCESS_SPLIT  = 8'h60;
  localparam logic [3:0]  RTWM_ACCESS_HIGH   = 4'hF;
  localparam logic [3:0]  RTWM_ACCESS_LOW    = 4'h0;
  localparam logic [15:0] RTWM_PROD_RESET    = 16'h0000;

  // decoded instruction from the core
  typedef struct packed {
    logic       valid;
    logic       access_sel;
    logic [7:0] file_addr;
  } rtwm_instr_s;

  // product pair as written to the core
  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } rtwm_prod_s;
endpackage

// *** src/rtwm_product_pair.sv ***
module rtwm_product_pair
  import rtwm_pkg::*;
(
  input  wire logic               clk,      // core clock
  input  wire logic               reset,    // async reset
  input  wire logic               write_en, // q4 write strobe
  input  wire rtwm_pkg::rtwm_prod_s wdata,  // product to store
  output      rtwm_pkg::rtwm_prod_s rdata   // registered pair
);
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= RTWM_PROD_RESET;
    end else if (write_en) begin
      rdata <= wdata;
    end
  end
endmodule // rtwm_product_pair

// *** src/rtwm_multiply_working_by_file.sv ***
module rtwm_multiply_working_by_file
  import rtwm_pkg::*;
(
  input  wire logic                 clk,               // core clock, one phase per rising edge
  input  wire logic                 reset,             // async reset
  input  wire rtwm_pkg::rtwm_instr_s instr,            // decoded instruction, sampled in q1
  input  wire logic [7:0]           working,           // working register
  input  wire logic [3:0]           bank_select_register, // bank select
  input  wire logic                 ext_enable,        // extended instruction set on
  input  wire logic [11:0]          fsr2,              // index base for literal offset
  input  wire logic [7:0]           mem_rdata,         // operand data, valid in q2
  output      logic [11:0]          mem_addr,          // operand address
  output      logic                 mem_rd,            // operand read strobe in q2
  output      logic [7:0]           product_high,      // high product byte
  output      logic [7:0]           product_low,       // low product byte
  output      logic                 prod_we,           // pulse after q4 write
  output      rtwm_pkg::rtwm_phase_e phase             // current q phase
);
  import rtwm_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    rtwm_phase_e phase;
    logic        busy;
    logic [11:0] addr;
    logic        rd;
    logic [7:0]  w_cap;
    logic [7:0]  f_cap;
    rtwm_prod_s  prod;
    logic        we;
  } rtwm_state_s;

  rtwm_state_s st;
  rtwm_state_s next_st;
  rtwm_prod_s  pair_q;

  // ****************************************
  // operand address resolution
  // ****************************************
  function automatic logic [11:0] resolve_addr(input rtwm_instr_s i, input logic [3:0] bank,
                                               input logic ext, input logic [11:0] base);
    logic [11:0] r;
    r = 12'h000;
    if (ext && !i.access_sel && i.file_addr <= RTWM_INDEXED_MAX) begin
      r = 12'(base + {4'h0, i.file_addr});
    end else if (!i.access_sel) begin
      r = {(i.file_addr < RTWM_ACCESS_SPLIT) ? RTWM_ACCESS_LOW : RTWM_ACCESS_HIGH, i.file_addr};
    end else begin
      r = {bank, i.file_addr};
    end
    return r;
  endfunction

  // ****************************************
  // phase sequencer
  // ****************************************
  always_comb begin
    next_st      = st;
    next_st.rd   = 1'b0;
    next_st.we   = 1'b0;
    unique case (st.phase)
      RTWM_Q1: begin
        next_st.phase = RTWM_Q2;
        next_st.busy  = instr.valid;
        if (instr.valid) begin
          next_st.addr = resolve_addr(instr, bank_select_register, ext_enable, fsr2);
          next_st.rd   = 1'b1;
        end
      end
      RTWM_Q2: begin
        next_st.phase = RTWM_Q3;
        if (st.busy) begin
          next_st.f_cap = mem_rdata;
          next_st.w_cap = working;
        end
      end
      RTWM_Q3: begin
        next_st.phase = RTWM_Q4;
        if (st.busy) begin
          next_st.prod = rtwm_prod_s'({8'h00, st.w_cap} * {8'h00, st.f_cap});
        end
      end
      RTWM_Q4: begin
        next_st.phase = RTWM_Q1;
        next_st.we    = st.busy;
        next_st.busy  = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      st <= '{phase: RTWM_Q1, busy: 1'b0, addr: 12'h000, rd: 1'b0, w_cap: 8'h00,
              f_cap: 8'h00, prod: RTWM_PROD_RESET, we: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // product pair and outputs
  // ****************************************
  // product pair store
  rtwm_product_pair u_pair (
    .clk      (clk),
    .reset    (reset),
    .write_en (st.phase == RTWM_Q4 && st.busy),
    .wdata    (st.prod),
    .rdata    (pair_q)
  );

  assign product_high = pair_q.high;
  assign product_low  = pair_q.low;
  assign mem_addr     = st.addr;
  assign mem_rd       = st.rd;
  assign prod_we      = st.we;
  assign phase        = st.phase;

  // ****************************************
  // checks
  // ****************************************
  property p_product;
    @(posedge clk) disable iff (reset)
      (st.phase == RTWM_Q4 && st.busy) |=> ({product_high, product_low} == st.w_cap * st.f_cap);
  endproperty
  a_product: assert property (p_product) else $error("product mismatch");
  property p_high_byte;
    @(posedge clk) disable iff (reset) prod_we |-> product_high == $past(st.prod.high);
  endproperty
  a_high_byte: assert property (p_high_byte) else $error("high byte wrong");
  property p_no_stray_write;
    @(posedge clk) disable iff (reset) !prod_we |-> $stable({product_high, product_low});
  endproperty
  a_no_stray_write: assert property (p_no_stray_write) else $error("pair changed without write");
  property p_pulse;
    @(posedge clk) disable iff (reset) prod_we |=> !prod_we;
  endproperty
  a_pulse: assert property (p_pulse) else $error("write pulse too long");
  property p_bank;
    @(posedge clk) disable iff (reset)
      (st.phase == RTWM_Q1 && instr.valid && instr.access_sel)
      |=> mem_addr == {$past(bank_select_register), $past(instr.file_addr)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank address wrong");
  property p_indexed;
    @(posedge clk) disable iff (reset)
      (st.phase == RTWM_Q1 && instr.valid && !instr.access_sel && ext_enable && instr.file_addr <= RTWM_INDEXED_MAX)
      |=> mem_addr == 12'($past(fsr2) + $past(instr.file_addr));
  endproperty
  a_indexed: assert property (p_indexed) else $error("indexed address wrong");
  property p_cycle;
    @(posedge clk) disable iff (reset) (st.phase == RTWM_Q1 && instr.valid) |=> mem_rd ##3 prod_we;
  endproperty
  a_cycle: assert property (p_cycle) else $error("instruction not done in one cycle");
  property p_order;
    @(posedge clk) disable iff (reset) phase == RTWM_Q1 |=> phase == RTWM_Q2 ##1 phase == RTWM_Q3 ##1 phase == RTWM_Q4;
  endproperty
  a_order: assert property (p_order) else $error("phase order wrong");
  property p_access_bank;
    @(posedge clk) disable iff (reset)
      (st.phase == RTWM_Q1 && instr.valid && !instr.access_sel &&
       !(ext_enable && instr.file_addr <= RTWM_INDEXED_MAX))
      |=> mem_addr[7:0] == $past(instr.file_addr) && mem_addr[11:8] ==
          (($past(instr.file_addr) < RTWM_ACCESS_SPLIT) ? RTWM_ACCESS_LOW : RTWM_ACCESS_HIGH);
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank address wrong");
  property p_capture;
    @(posedge clk) disable iff (reset)
      (st.phase == RTWM_Q2 && st.busy) |=> st.w_cap == $past(working) && st.f_cap == $past(mem_rdata);
  endproperty
  a_capture: assert property (p_capture) else $error("operand capture wrong");
  property p_rd_phase;
    @(posedge clk) disable iff (reset) mem_rd |-> phase == RTWM_Q2;
  endproperty
  a_rd_phase: assert property (p_rd_phase) else $error("read outside q2");
  property p_we_phase;
    @(posedge clk) disable iff (reset) prod_we |-> phase == RTWM_Q1;
  endproperty
  a_we_phase: assert property (p_we_phase) else $error("write pulse outside q1");
  property p_idle;
    @(posedge clk) disable iff (reset) (st.phase == RTWM_Q1 && !instr.valid) |=> !mem_rd ##3 !prod_we;
  endproperty
  a_idle: assert property (p_idle) else $error("activity without instruction");
  property p_addr_hold;
    @(posedge clk) disable iff (reset) (phase != RTWM_Q1) |=> $stable(mem_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved mid cycle");
  property p_low_byte;
    @(posedge clk) disable iff (reset) prod_we |-> product_low == $past(st.prod.low);
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte wrong");
  property p_operands_kept;
    @(posedge clk) disable iff (reset) (st.phase == RTWM_Q3) |=> $stable(st.w_cap) && $stable(st.f_cap);
  endproperty
  a_operands_kept: assert property (p_operands_kept) else $error("operand copy changed");
  property p_wrap;
    @(posedge clk) disable iff (reset) phase == RTWM_Q4 |=> phase == RTWM_Q1;
  endproperty
  a_wrap: assert property (p_wrap) else $error("q4 not followed by q1");
endmodule // rtwm_multiply_working_by_file

// *** tb/rtwm_mem_model.sv ***
module rtwm_mem_model
  import rtwm_pkg::*;
(
  input  wire logic        clk,      // core clock
  input  wire logic [11:0] mem_addr, // operand address
  input  wire logic        mem_rd,   // read strobe
  output      logic [7:0]  mem_rdata // operand data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] last = 8'h00;
  // read only store
  // outside a read the bus shows a changing pattern, never the old value
  always_comb begin
    if (mem_rd) begin
      mem_rdata = 8'(int'(mem_addr) * 37 + 11);
    end else begin
      mem_rdata = ~last;
    end
  end
  always_ff @(posedge clk) begin
    last <= mem_rdata;
  end
endmodule // rtwm_mem_model

// *** tb/register_times_working_multiply_bench.sv ***
module register_times_working_multiply_bench;
  timeunit 1ns;
  timeprecision 1ns;
  import rtwm_pkg::*;
  logic clk, reset, ext_enable, mem_rd, prod_we;
  rtwm_instr_s instr;
  logic [7:0] working, mem_rdata, product_high, product_low, seed, r1, r2;
  logic [3:0] bank;
  logic [11:0] fsr2, mem_addr;
  rtwm_phase_e phase;
  int num_errors = 0, total_checks = 0, cycles = 0;
  int exp_addr[$], exp_prod[$];
  rtwm_multiply_working_by_file rtwm_multiply_working_by_file_inst (.clk(clk), .reset(reset), .instr(instr),
    .working(working), .bank_select_register(bank), .ext_enable(ext_enable), .fsr2(fsr2),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_rd(mem_rd), .product_high(product_high),
    .product_low(product_low), .prod_we(prod_we), .phase(phase));
  rtwm_mem_model rtwm_mem_model_inst (.clk(clk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_rdata(mem_rdata));
  function automatic logic [7:0] lfsr(logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // launch in the Q1 after the running Q4, so operations go back to back
  task automatic do_op(input logic a, input logic [7:0] f, w, input logic [3:0] b, input logic e,
                       input logic [11:0] base);
    int ad;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      if (phase === RTWM_Q4) break;
    end
    if (e && !a && f <= RTWM_INDEXED_MAX) ad = (int'(base) + int'(f)) % 4096;
    else if (!a) ad = int'({(f < RTWM_ACCESS_SPLIT) ? RTWM_ACCESS_LOW : RTWM_ACCESS_HIGH, f});
    else ad = int'({b, f});
    exp_addr.push_back(ad);
    exp_prod.push_back(int'(w) * ((ad * 37 + 11) % 256));
    @(posedge clk);
    instr <= '{1'b1, a, f};
    working <= w;
    bank <= b;
    ext_enable <= e;
    fsr2 <= base;
    @(posedge clk);
    instr.valid <= 1'b0;
  endtask
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      num_errors++;
      conclude();
    end
  end
  always @(negedge clk) begin
    if (!reset && mem_rd === 1'b1) begin
      chk(16'(phase), 16'(RTWM_Q2));
      chk(16'(mem_addr), 16'(exp_addr.pop_front()));
    end
    if (!reset && prod_we === 1'b1) begin
      chk(16'(phase), 16'(RTWM_Q1));
      chk({product_high, product_low}, 16'(exp_prod.pop_front()));
    end
  end
  initial begin
    reset = 1'b1;
    instr = '0;
    {working, bank, ext_enable, fsr2} = '0;
    seed = 8'h34;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(negedge clk);
    chk({product_high, product_low}, RTWM_PROD_RESET);
    do_op(1'b0, 8'h5F, 8'hFF, 4'h3, 1'b1, 12'hFF0);
    do_op(1'b0, 8'h60, 8'h01, 4'h3, 1'b1, 12'h100);
    do_op(1'b0, 8'h00, 8'hC4, 4'h7, 1'b0, 12'h200);
    do_op(1'b0, 8'hFF, 8'h80, 4'h7, 1'b0, 12'h200);
    do_op(1'b1, 8'h10, 8'h00, 4'hA, 1'b1, 12'h300);
    $display("corner test done");
    repeat (40) begin
      seed = lfsr(seed);
      r1 = seed;
      seed = lfsr(seed);
      r2 = seed;
      do_op(r1[7], r2, r1, r1[3:0] ^ r2[7:4], r1[6], {r1[3:0], r2});
    end
    repeat (8) @(negedge clk);
    chk(16'(exp_prod.size()), 16'h0000);
    $display("random test done");
    conclude();
  end
endmodule // register_times_working_multiply_bench
